// ### inc/card_decode_pkg.sv
// Package for the card host access decode block.
// Assumes one 125 MHz clock and an active-low asynchronous reset.
package card_decode_pkg;
   // Clock period in nanoseconds
   localparam int          CLK_PERIOD_NS     = 8;
   // Least time that a wait assertion lasts before release, in ns
   localparam int          WAIT_MIN_NS       = 16;
   localparam int          WAIT_MIN_CYC      = (WAIT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Reset values of the active-low outputs (inactive high)
   localparam logic        NWAIT_RST         = 1'h1;
   localparam logic        NIREQ_RST         = 1'h1;
   localparam logic        NEVENT_RST        = 1'h1;
   localparam logic        NIOIS16_RST       = 1'h1;
   // Idle levels of the synchronised pins: host reset low, all else high
   localparam logic [8:0]  PIN_IDLE          = 9'h0FF;
   // Byte lane codes
   localparam logic [1:0]  LANE_NONE         = 2'h0;
   localparam logic [1:0]  LANE_LOW          = 2'h1;
   localparam logic [1:0]  LANE_HIGH         = 2'h2;
   localparam logic [1:0]  LANE_BOTH         = 2'h3;
   // Access cycle state machine
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WAIT = 2'b01,
      ST_DONE = 2'b10
   } cyc_state_type;
endpackage

// ### rtl/card_host_decode.sv
// Host access decode of a network controller on a PC Card socket.
// Assumes the host socket controller drives enables, strobes and address
// asynchronously; the core side answers with ready and receive events.
//
// Behaviour
// [R1] Host drives two active-low card enables
// [R2] Both enables high means bus idle
// [R3] Low enable only: byte access, A0 picks
// [R4] Both enables low: word access, A0 ignored
// [R5] High enable only: odd byte on upper lanes
// [R6] Space select low attribute, high common
// [R7] Host holds space select low for I/O
// [R8] Wait low lengthens the host cycle
// [R9] Interrupt output low requests service
// [R10] Reset input active high holds device
// [R11] Enabled wake event low on frame received
// [R12] Wake event holds until receive acknowledge
// [R13] 16-bit I/O indication low for I/O cycles; here held low whenever out of host reset
// [R14] Host strobes are active low
// [R15] Release wait once data valid or accepted
`timescale 1ns/10ps
`default_nettype none
module card_host_decode
   import card_decode_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        nrst_i,
   // Host socket pins
   input  wire logic        host_reset_i,
   input  wire logic        card_en1_n_i,
   input  wire logic        card_en2_n_i,
   input  wire logic        attr_sel_n_i,
   input  wire logic        addr0_i,
   input  wire logic        mem_rd_n_i,
   input  wire logic        mem_wr_n_i,
   input  wire logic        io_rd_n_i,
   input  wire logic        io_wr_n_i,
   output logic             wait_n_o,
   output logic             ireq_n_o,
   output logic             event_n_o,
   output logic             iois16_n_o,
   // Core side
   input  wire logic        core_ready_i,
   input  wire logic        irq_pending_i,
   input  wire logic        wake_enable_i,
   input  wire logic        frame_received_i,
   input  wire logic        rcv_irq_ack_i,
   output logic             core_reset_o,
   output logic             access_start_o,
   output logic [1:0]       lane_sel_o,
   output logic             odd_byte_o,
   output logic             attr_space_o,
   output logic             io_access_o,
   output logic             write_o
);

   // Pin count in the synchroniser
   // Must match the width of the pin idle pattern
   localparam int NSYNC = 9;

   // Three-stage synchronisers, one per pin
   logic [NSYNC-1:0] pin_in;
   logic [NSYNC-1:0] s1_r;
   logic [NSYNC-1:0] s2_r;
   logic [NSYNC-1:0] s3_r;
   logic [NSYNC-1:0] clean_r;      // Debounced pin values

   // Bit order: host reset on top, then enables, space select, A0, strobes
   assign pin_in = {host_reset_i, card_en1_n_i, card_en2_n_i, attr_sel_n_i, addr0_i,
                    mem_rd_n_i, mem_wr_n_i, io_rd_n_i, io_wr_n_i};

   // Per pin: a change counts once stages two and three agree
   // Trade-off: every pin pays four edges of latency, which the wait covers
   genvar g;
   generate
      for (g = 0; g < NSYNC; g++) begin : g_sync
         always_ff @(posedge clk_i or negedge nrst_i) begin
            if (!nrst_i) begin
               // Every stage starts at the pin's idle level, so that no
               // false strobe or host reset appears once reset lifts
               s1_r[g]    <= PIN_IDLE[g];
               s2_r[g]    <= PIN_IDLE[g];
               s3_r[g]    <= PIN_IDLE[g];
               clean_r[g] <= PIN_IDLE[g];
            end else begin
               s1_r[g] <= pin_in[g];
               s2_r[g] <= s1_r[g];
               s3_r[g] <= s2_r[g];
               // A pin still in motion keeps its last clean value
               if (s2_r[g] == s3_r[g]) begin
                  clean_r[g] <= s3_r[g];
               end
            end
         end
      end
   endgenerate

   // Named clean pins
   // Pins settle independently; a host that moves enables and strobes
   // together gives one consistent decode edge
   wire hrst    = clean_r[8];
   wire ce1_n   = clean_r[7];
   wire ce2_n   = clean_r[6];
   wire reg_n   = clean_r[5];
   wire a0      = clean_r[4];
   wire mrd_n   = clean_r[3];
   wire mwr_n   = clean_r[2];
   wire iord_n  = clean_r[1];
   wire iowr_n  = clean_r[0];

   // Decode
   // Plain decode on the clean pins; no state involved
   wire bus_idle  = ce1_n & ce2_n;                                  // R2
   wire io_cmd    = ~iord_n | ~iowr_n;
   wire mem_cmd   = ~mrd_n | ~mwr_n;                                // R14
   wire cmd_any   = io_cmd | mem_cmd;
   // A strobe counts only while the card is selected and out of reset
   wire strobe    = ~bus_idle & cmd_any & ~hrst;                    // R2
   wire is_write  = ~mwr_n | ~iowr_n;
   // Lane choice from the two enables
   // Byte mode keeps the data on the low lanes; A0 only names the byte
   wire [1:0] lanes_d = (!ce1_n && !ce2_n) ? LANE_BOTH :            // R4
                        (!ce1_n)           ? LANE_LOW :             // R3
                        (!ce2_n)           ? LANE_HIGH :            // R5
                                             LANE_NONE;
   // Odd byte: A0 counts only in byte mode
   wire odd_d     = (!ce1_n && ce2_n) ? a0 : (ce1_n && !ce2_n);     // R3 R5
   // Space select taken as driven; I/O cycles rely on the host holding it low
   wire attr_d    = ~reg_n;                                         // R6 R7

   // Cycle state
   cyc_state_type state_r;
   cyc_state_type state_nxt;
   // The counter saturates at the minimum, so two bits are enough
   logic [1:0]    wcnt_r;          // Least wait length counter
   logic [1:0]    wcnt_nxt;

   // Next state: wait held until core ready and minimum elapsed
   // The minimum gives the core a fixed head start before ready counts
   always_comb begin
      state_nxt = state_r;
      wcnt_nxt  = wcnt_r;
      case (state_r)
         ST_IDLE: begin
            // Counter restarts for every host cycle
            wcnt_nxt = 2'h0;
            if (strobe) begin
               state_nxt = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (wcnt_r < 2'(WAIT_MIN_CYC)) begin
               wcnt_nxt = wcnt_r + 2'h1;
            end
            // A host that drops its strobe early gets no data phase
            if (!strobe) begin
               state_nxt = ST_IDLE;          // Host aborted
            end else if (core_ready_i && wcnt_r >= 2'(WAIT_MIN_CYC - 1)) begin
               state_nxt = ST_DONE;          // R15
            end
         end
         ST_DONE: begin
            // Wait stays released until the host drops its strobe
            if (!strobe) begin
               state_nxt = ST_IDLE;
            end
         end
         default: state_nxt = ST_IDLE;
      endcase
   end

   // State registers; host reset forces idle
   // Host reset wins over any cycle in flight, so the core sees no half access
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_r <= ST_IDLE;
         wcnt_r  <= 2'h0;
      end else if (hrst) begin
         state_r <= ST_IDLE;                 // R10
         wcnt_r  <= 2'h0;
      end else begin
         state_r <= state_nxt;
         wcnt_r  <= wcnt_nxt;
      end
   end

   // Output registers
   logic wake_r;                   // Wake event latched
   logic start_r;
   // Start pulses for one cycle as the state machine leaves idle
   wire  start_nxt = (state_r == ST_IDLE) && strobe;

   // Pin outputs and latched decode
   // Wait follows the next state, so it falls on the same edge as the start
   // Decode is captured once per cycle and then held for the core
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         wait_n_o       <= NWAIT_RST;
         ireq_n_o       <= NIREQ_RST;
         iois16_n_o     <= NIOIS16_RST;
         core_reset_o   <= 1'h1;
         start_r        <= 1'h0;
         lane_sel_o     <= LANE_NONE;
         odd_byte_o     <= 1'h0;
         attr_space_o   <= 1'h0;
         io_access_o    <= 1'h0;
         write_o        <= 1'h0;
      end else begin
         // All pin outputs go inactive while the host holds reset
         core_reset_o <= hrst;                                       // R10
         wait_n_o     <= ~(state_nxt == ST_WAIT) | hrst;             // R8 R15
         ireq_n_o     <= ~irq_pending_i | hrst;                      // R9
         // Card is a 16-bit design, so advertise it whenever not in reset
         iois16_n_o   <= hrst;                                       // R13
         start_r      <= start_nxt & ~hrst;
         if (start_nxt) begin
            lane_sel_o   <= lanes_d;
            odd_byte_o   <= odd_d;
            attr_space_o <= attr_d;
            io_access_o  <= io_cmd;
            write_o      <= is_write;
         end
      end
   end
   assign access_start_o = start_r;

   // Wake event: set wins over acknowledge
   // Limitation: a frame that lands with the acknowledge keeps it low
   // Host reset clears a pending wake, since the core restarts as well
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         wake_r <= 1'h0;
      end else if (hrst) begin
         wake_r <= 1'h0;
      end else if (wake_enable_i && frame_received_i) begin
         wake_r <= 1'h1;                                             // R11
      end else if (rcv_irq_ack_i) begin
         wake_r <= 1'h0;                                             // R12
      end
   end
   assign event_n_o = ~wake_r;

   // Assertions
   // They watch the clean pin values, so they judge what the decode saw
   // Idle bus: no start and no wait
   a_idle_no_start: assert property (@(posedge clk_i) disable iff (!nrst_i) // R2
      bus_idle |=> !start_r) else $error("access started while idle");
   a_idle_no_wait: assert property (@(posedge clk_i) disable iff (!nrst_i) // R2
      bus_idle |=> wait_n_o) else $error("wait driven while idle");
   // Word access: both lanes, even start
   a_word_lanes: assert property (@(posedge clk_i) disable iff (!nrst_i) // R4
      start_nxt && !ce1_n && !ce2_n |=> lane_sel_o == LANE_BOTH)
      else $error("word access lanes wrong");
   a_word_even: assert property (@(posedge clk_i) disable iff (!nrst_i) // R4
      start_nxt && !ce1_n && !ce2_n |=> !odd_byte_o)
      else $error("word access flagged odd");
   // Byte access: low lanes, A0 names the byte
   a_byte_lane: assert property (@(posedge clk_i) disable iff (!nrst_i) // R3
      start_nxt && !ce1_n && ce2_n |=> lane_sel_o == LANE_LOW && odd_byte_o == $past(a0))
      else $error("byte lane wrong");
   // Odd-byte-only access on the upper lanes
   a_odd_only: assert property (@(posedge clk_i) disable iff (!nrst_i) // R5
      start_nxt && ce1_n && !ce2_n |=> lane_sel_o == LANE_HIGH && odd_byte_o)
      else $error("odd byte access wrong");
   // Space select
   a_space_sel: assert property (@(posedge clk_i) disable iff (!nrst_i) // R6
      start_nxt |=> attr_space_o == !$past(reg_n)) else $error("space select wrong");
   // Wait: falls with the start, lasts the minimum, lifts on ready
   // Ready before the minimum is held off by the counter
   a_wait_start: assert property (@(posedge clk_i) disable iff (!nrst_i) // R8
      start_nxt |=> !wait_n_o) else $error("wait not asserted");
   a_wait_min: assert property (@(posedge clk_i) disable iff (!nrst_i) // R8
      start_r && strobe |=> !wait_n_o) else $error("wait shorter than minimum");
   a_wait_release: assert property (@(posedge clk_i) disable iff (!nrst_i) // R15
      state_r == ST_DONE |-> wait_n_o) else $error("wait held after ready");
   a_done_hold: assert property (@(posedge clk_i) disable iff (!nrst_i) // R15
      state_r == ST_DONE && strobe |=> state_r == ST_DONE && wait_n_o)
      else $error("wait fell again after ready");
   // Interrupt mirror
   a_irq_follow: assert property (@(posedge clk_i) disable iff (!nrst_i) // R9
      irq_pending_i && !hrst |=> !ireq_n_o) else $error("interrupt not driven");
   a_irq_release: assert property (@(posedge clk_i) disable iff (!nrst_i) // R9
      !irq_pending_i |=> ireq_n_o) else $error("interrupt not released");
   // Wake event
   // Acknowledge alone clears it; set wins when both land
   a_wake_hold: assert property (@(posedge clk_i) disable iff (!nrst_i) // R12
      !event_n_o && !rcv_irq_ack_i && !hrst |=> !event_n_o) else $error("wake dropped");
   a_wake_set: assert property (@(posedge clk_i) disable iff (!nrst_i) // R11
      wake_enable_i && frame_received_i && !hrst |=> !event_n_o) else $error("wake missed");
   // Host reset, seen through the synchroniser four edges late
   a_reset_hold: assert property (@(posedge clk_i) disable iff (!nrst_i) // R10
      hrst |=> core_reset_o && state_r == ST_IDLE) else $error("reset not held");
   a_reset_quiet: assert property (@(posedge clk_i) disable iff (!nrst_i) // R10
      hrst |=> wait_n_o && ireq_n_o && event_n_o && iois16_n_o)
      else $error("outputs active in host reset");
   // 16-bit indication
   a_io16: assert property (@(posedge clk_i) disable iff (!nrst_i) // R13
      !hrst |=> !iois16_n_o) else $error("16-bit indication missing");

   // Main scenarios
   c_word: cover property (@(posedge clk_i) start_nxt && !ce1_n && !ce2_n);
   c_byte_odd: cover property (@(posedge clk_i) start_nxt && !ce1_n && ce2_n && a0);
   c_odd_only: cover property (@(posedge clk_i) start_nxt && ce1_n && !ce2_n);
   c_wait_done: cover property (@(posedge clk_i) state_r == ST_WAIT ##1 state_r == ST_DONE);
   c_wake: cover property (@(posedge clk_i) !event_n_o ##1 event_n_o);

endmodule
`default_nettype wire

// ### testbench/host_socket_model.sv
// Host socket model: drives enables, space select, A0 and strobes.
// Assumes tasks are called just after a rising clock edge.
`timescale 1ns/10ps
`default_nettype none
module host_socket_model (
   // Clock
   input  wire logic       clk_i,
   // Card pins
   input  wire logic       wait_n_i,
   output logic            en1_n_o,
   output logic            en2_n_o,
   output logic            attr_n_o,
   output logic            a0_o,
   output logic [3:0]      strb_n_o
);
   // Socket starts with nothing selected
   initial begin
      {en1_n_o, en2_n_o, attr_n_o, a0_o, strb_n_o} = 8'hFF;
   end
   // Open a cycle; kinds 0..3 are mem read, mem write, io read, io write
   task automatic start(input logic e1, e2, a, sp, input int k);
      en1_n_o = e1;
      en2_n_o = e2;
      a0_o = a;
      attr_n_o = (k > 1) ? 1'h0 : sp;
      strb_n_o = ~(4'h1 << k);
   endtask
   // Hold the cycle until wait is sampled high, then release
   task automatic finish(output bit ok);
      ok = 0;
      for (int i = 0; i < 40 && !ok; i++) begin
         @(posedge clk_i);
         #1;
         ok = (wait_n_i === 1'h1);
      end
      strb_n_o = 4'hF;
      {en1_n_o, en2_n_o} = 2'h3;
      // A released address line must not keep its last value
      a0_o = ~a0_o;
   endtask
endmodule
`default_nettype wire

// ### testbench/tb_card_host_decode.sv
// Bench for the card host access decode block.
// Assumes the socket model drives the pins and the bench the core side.
`timescale 1ns/10ps
`default_nettype none
module tb_card_host_decode
   import card_decode_pkg::*;
;
   // Clock, reset and core side inputs
   logic clk_i = 0, nrst_i = 0, host_reset_i = 0, core_ready_i = 0;
   logic irq_pending_i = 0, wake_enable_i = 0, frame_received_i = 0, rcv_irq_ack_i = 0;
   // Socket pins
   logic en1_n, en2_n, attr_n, a0, wait_n, ireq_n, event_n, iois16_n;
   logic [3:0] strb_n;
   // Core side outputs
   logic core_reset, start, odd, attr_sp, io, wr;
   logic [1:0] lane;
   int n_errors = 0, n_compared = 0;
   initial forever #4 clk_i = ~clk_i;
   host_socket_model i_host (.clk_i(clk_i), .wait_n_i(wait_n), .en1_n_o(en1_n),
      .en2_n_o(en2_n), .attr_n_o(attr_n), .a0_o(a0), .strb_n_o(strb_n));
   card_host_decode i_dut (.clk_i(clk_i), .nrst_i(nrst_i), .host_reset_i(host_reset_i),
      .card_en1_n_i(en1_n), .card_en2_n_i(en2_n), .attr_sel_n_i(attr_n), .addr0_i(a0),
      .mem_rd_n_i(strb_n[0]), .mem_wr_n_i(strb_n[1]), .io_rd_n_i(strb_n[2]),
      .io_wr_n_i(strb_n[3]), .wait_n_o(wait_n), .ireq_n_o(ireq_n), .event_n_o(event_n),
      .iois16_n_o(iois16_n), .core_ready_i(core_ready_i), .irq_pending_i(irq_pending_i),
      .wake_enable_i(wake_enable_i), .frame_received_i(frame_received_i),
      .rcv_irq_ack_i(rcv_irq_ack_i), .core_reset_o(core_reset), .access_start_o(start),
      .lane_sel_o(lane), .odd_byte_o(odd), .attr_space_o(attr_sp), .io_access_o(io),
      .write_o(wr));
   // Compare and count
   task automatic check(string what, logic [1:0] seen, logic [1:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Step n edges, then settle 1 ns past the last one
   task automatic tick(int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic summarize;
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // Bounded wait for start (sel 0) or wait (sel 1) high; running out ends the run
   task automatic await(input int sel, input int lim, string what);
      logic v;
      v = sel ? wait_n : start;
      for (int i = 0; i < lim && v !== 1'h1; i++) begin
         tick(1);
         v = sel ? wait_n : start;
      end
      if (v !== 1'h1) begin
         check(what, {1'h0, v}, 2'h1);
         summarize();
      end
   endtask
   // One host cycle: decode, wait held while core busy, release on ready
   task automatic access(logic e1, e2, a, sp, int k, logic [1:0] lx);
      bit ok;
      i_host.start(e1, e2, a, sp, k);
      await(0, 12, "start");
      check("lane", lane, lx);
      check("odd", odd, {1'h0, e1 | (e2 & a)});
      check("space", attr_sp, (k > 1) ? 2'h1 : {1'h0, ~sp});
      check("io wr", {io, wr}, 2'(k));
      repeat (4) begin
         tick(1);
         check("wait", wait_n, 2'h0);
      end
      core_ready_i = 1;
      await(1, 2, "wait end");
      i_host.finish(ok);
      core_ready_i = 0;
      check("done", ok, 2'h1);
      tick(8);
   endtask
   // Strobe with no enable must stay unanswered
   task automatic idle_bus;
      bit ok;
      i_host.start(1, 1, 0, 0, 0);
      repeat (10) begin
         tick(1);
         check("idle", {start, wait_n}, 2'h1);
      end
      i_host.finish(ok);
      tick(8);
   endtask
   // Interrupt mirror, then wake with and without enable
   task automatic events;
      irq_pending_i = 1;
      tick(3);
      check("irq", ireq_n, 2'h0);
      irq_pending_i = 0;
      tick(3);
      check("irq off", ireq_n, 2'h1);
      for (int en = 0; en < 2; en++) begin
         wake_enable_i = en[0];
         frame_received_i = 1;
         tick(1);
         frame_received_i = 0;
         tick(8);
         check("wake", event_n, {1'h0, !en[0]});
         rcv_irq_ack_i = 1;
         tick(1);
         rcv_irq_ack_i = 0;
         tick(3);
         check("wake ack", event_n, 2'h1);
      end
      // Frame and acknowledge on one edge: the new frame wins
      frame_received_i = 1;
      rcv_irq_ack_i = 1;
      tick(1);
      {frame_received_i, rcv_irq_ack_i} = 2'h0;
      tick(2);
      check("wake vs ack", event_n, 2'h0);
   endtask
   // Host reset pin holds the core in reset
   task automatic host_rst;
      check("io16", iois16_n, 2'h0);
      host_reset_i = 1;
      tick(8);
      check("hold", {core_reset, iois16_n}, 2'h3);
      host_reset_i = 0;
      tick(8);
      check("run", core_reset, 2'h0);
   endtask
   initial begin
      repeat (12) @(posedge clk_i);
      check("rst out", {core_reset, wait_n}, 2'h3);
      check("rst evt", {ireq_n, event_n}, 2'h3);
      #1 nrst_i = 1;
      tick(8);
      host_rst();
      idle_bus();
      access(0, 1, 0, 1, 0, LANE_LOW);
      access(0, 1, 1, 0, 1, LANE_LOW);
      access(0, 0, 1, 0, 2, LANE_BOTH);
      access(1, 0, 0, 0, 3, LANE_HIGH);
      events();
      summarize();
   end
endmodule
`default_nettype wire
